// >>> core/fbst_ccm.sv
// Fixed-frequency CCM period timer with frequency dithering
`timescale 1ns/1ps
`include "fbst_map.svh"
module fbst_ccm (
  fbst_if.ccm bus // Controller side
);
  import fbst_pkg::*;
  logic [6:0]  lfsr_q;
  logic [15:0] cnt_q;
  logic [15:0] tgt_q;
  logic        slope_q;
  logic [15:0] spread;
  // ----------------------------------------------------------------
  // Dither: pseudo-random spread inside the plus/minus band, never reaching either end (spread 1 to 2*D-1)
  // ----------------------------------------------------------------
  assign spread = 16'((32'(lfsr_q) * (2 * `FBST_DITHER_CYC + 1)) >> 7);
  // New period target and random step at each cycle start
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      lfsr_q <= `FBST_LFSR_SEED;
      tgt_q  <= 16'(`FBST_CCM_PER_CYC);
    end else if (bus.cycle_start) begin
      lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
      tgt_q  <= 16'(`FBST_CCM_PER_CYC - `FBST_DITHER_CYC) + spread;
    end
  end
  // Period counter from the last cycle start, saturating
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      cnt_q <= 16'h0000;
    end else if (bus.cycle_start) begin
      cnt_q <= 16'h0001;
    end else if (cnt_q != 16'hffff) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // Slope compensation follows the mode
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      slope_q <= 1'b0;
    end else begin
      slope_q <= bus.ccm_mode && !bus.clr;
    end
  end
  assign bus.ccm_tick = bus.ccm_mode && (cnt_q >= tgt_q);
  assign bus.slope_en = slope_q;

  AST_CCM_EXIT: assert property (@(posedge bus.clk) disable iff (bus.rst)
    !bus.ccm_mode |=> !slope_q)
    else $error("slope compensation stayed on outside CCM");
endmodule

// >>> core/fbst_if.sv
// Signals between the cycle controller and its plateau and CCM helpers
`timescale 1ns/1ps
interface fbst_if (
  input wire logic clk, // Block clock
  input wire logic rst  // Asynchronous reset, high
);
  logic clr;           // Lockout clear of latched state
  logic cycle_start;   // Pulse: gate turns on
  logic flyback_start; // Pulse: on-phase ends normally
  logic plateau_high;  // Plateau above trip level
  logic ccm_mode;      // Fixed-frequency CCM selected
  logic ovp_fault;     // Latched over-voltage stop
  logic ccm_tick;      // CCM period elapsed
  logic slope_en;      // Slope compensation on
  modport top (output clr, cycle_start, flyback_start, plateau_high, ccm_mode,
               input ovp_fault, ccm_tick, slope_en);
  modport ovp (input clk, rst, clr, flyback_start, plateau_high, output ovp_fault);
  modport ccm (input clk, rst, clr, cycle_start, ccm_mode, output ccm_tick, slope_en);
endinterface

// >>> core/fbst_map.svh
// Timing and level constants of the flyback switch timing and protection block
`ifndef FBST_MAP_SVH
`define FBST_MAP_SVH
// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define FBST_CLK_HZ       100000000
`define FBST_CLK_MHZ      100
// ----------------------------------------------------------------
// Times and their cycle counts
// ----------------------------------------------------------------
`define FBST_BLANK_NS     300
`define FBST_BLANK_CYC    ((`FBST_BLANK_NS * `FBST_CLK_MHZ + 999) / 1000)
`define FBST_TON_MAX_NS   12500
`define FBST_TON_MAX_CYC  ((`FBST_TON_MAX_NS * `FBST_CLK_MHZ) / 1000)
`define FBST_FMAX_HZ      95000
`define FBST_PER_MIN_CYC  ((`FBST_CLK_HZ + `FBST_FMAX_HZ - 1) / `FBST_FMAX_HZ)
`define FBST_SUPP_NS      2500
`define FBST_SUPP_CYC     ((`FBST_SUPP_NS * `FBST_CLK_MHZ) / 1000)
`define FBST_PLAT_NS      2500
`define FBST_PLAT_CYC     ((`FBST_PLAT_NS * `FBST_CLK_MHZ + 999) / 1000)
`define FBST_CCM_HZ       52000
`define FBST_CCM_PER_CYC  (`FBST_CLK_HZ / `FBST_CCM_HZ)
`define FBST_DITHER_PCT   5
`define FBST_DITHER_CYC   ((`FBST_CCM_PER_CYC * `FBST_DITHER_PCT) / 100)
`define FBST_OFF_MAX_NS   65000
`define FBST_OFF_MAX_CYC  ((`FBST_OFF_MAX_NS * `FBST_CLK_MHZ) / 1000)
`define FBST_OLP_MS       80
`define FBST_OLP_CYC      ((`FBST_CLK_HZ / 1000) * `FBST_OLP_MS)
`define FBST_SS_MS        4
`define FBST_SS_CYC       ((`FBST_CLK_HZ / 1000) * `FBST_SS_MS)
// ----------------------------------------------------------------
// Levels, counts and reset values
// ----------------------------------------------------------------
`define FBST_OCP_LO_MV    450
`define FBST_OCP_HI_MV    800
`define FBST_OVP_RUN      4
`define FBST_LFSR_SEED    7'h5a
`define FBST_SYNC_RST     10'h001
`endif

// >>> core/fbst_ovp.sv
// Output over-voltage plateau sampler and successive-event counter
`timescale 1ns/1ps
`include "fbst_map.svh"
module fbst_ovp (
  fbst_if.ovp bus // Controller side
);
  import fbst_pkg::*;
  logic       armed_q;
  logic [7:0] dly_q;
  logic [2:0] run_q;
  logic       fault_q;
  logic       sample;
  // ----------------------------------------------------------------
  // Plateau delay
  // ----------------------------------------------------------------
  assign sample = armed_q && (dly_q == 8'(`FBST_PLAT_CYC - 1));
  // Delay runs from the start of each flyback phase
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      armed_q <= 1'b0;
      dly_q   <= 8'h00;
    end else if (bus.flyback_start) begin
      armed_q <= 1'b1;
      dly_q   <= 8'h00;
    end else if (armed_q) begin
      armed_q <= !sample;
      dly_q   <= dly_q + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // Successive-event counter and latched fault
  // ----------------------------------------------------------------
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      run_q <= 3'h0;
    end else if (bus.clr) begin
      run_q <= 3'h0;
    end else if (sample) begin
      run_q <= bus.plateau_high ? run_q + 3'h1 : 3'h0;
    end
  end
  // Fault holds until the lockout clear
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      fault_q <= 1'b0;
    end else if (bus.clr) begin
      fault_q <= 1'b0;
    end else if (sample && bus.plateau_high && run_q == 3'(`FBST_OVP_RUN - 1)) begin
      fault_q <= 1'b1;
    end
  end
  assign bus.ovp_fault = fault_q;

  AST_OVP_TRIP: assert property (@(posedge bus.clk) disable iff (bus.rst)
    sample && bus.plateau_high && !bus.clr && run_q == 3'h3 |=> fault_q)
    else $error("fourth successive event did not latch the fault");
  AST_OVP_CLEAR: assert property (@(posedge bus.clk) disable iff (bus.rst)
    sample && !bus.plateau_high && !fault_q |=> run_q == 3'h0 && !fault_q)
    else $error("quiet cycle did not clear the event run");
  AST_OVP_HOLD: assert property (@(posedge bus.clk) disable iff (bus.rst)
    fault_q && !bus.clr |=> fault_q)
    else $error("fault dropped without lockout");
endmodule

// >>> core/fbst_pkg.sv
// Types shared by the flyback switch timing and protection block
package fbst_pkg;
  // Switching cycle phases, Gray coded along idle-on-supp-off
  typedef enum logic [1:0] {
    FBST_IDLE = 2'b00,
    FBST_ON   = 2'b01,
    FBST_SUPP = 2'b11,
    FBST_OFF  = 2'b10
  } fbst_state_t;
  // Overcurrent threshold in millivolts
  typedef logic [9:0] fbst_mv_t;
endpackage

// >>> core/fbst_top.sv
// Flyback switch timing and protection controller
//
// Overview of operation
// - Current-limit comparator ignored during leading-edge blanking window
// - On-phase never ends before blanking window elapsed unless inhibit forces idle; blanking is minimum on-time
// - Gate forced off after 12.5 us of on-time
// - New cycle no sooner than the 95 kHz period after previous start
// - Sense reaching feedback level turns gate off and starts suppression
// - Gate held off, turn-on refused during whole suppression interval
// - Suppression lasts 2.5 us; demag detection ignored meanwhile
// - Below 12.5 us on-time threshold rises linearly 0.45 V to 0.8 V
// - Past maximum on-time threshold held at 0.8 V
// - In fixed-frequency CCM, dither +/-5% around 52 kHz, slope compensation on
// - Leaving CCM stops dithering and slope compensation
// - Plateau sampled 2.5 us after start of each flyback phase
// - Plateau above 3.75 V counts an over-voltage event
// - Four successive over-voltage events latch fault, stop switching
// - A quiet cycle clears the event counter, no fault
// - Feedback open level over 80 ms stops gate pulses, auto-recovery
// - After overload stop, lockout restarts through soft start
// - Floating sense, feedback or demag input disables switching
// - Gate held low while supply below lockout turn-on level
// - Soft start ramps over 4 ms at power-on and each restart
`timescale 1ns/1ps
`include "fbst_map.svh"
module fbst_top #(
  parameter int unsigned OLP_CYC     = `FBST_OLP_CYC,    // Overload persistence
  parameter int unsigned SS_CYC      = `FBST_SS_CYC,     // Soft start ramp
  parameter int unsigned OFF_MAX_CYC = `FBST_OFF_MAX_CYC // Restart without valley
) (
  input  wire logic         CLK,           // 100 MHz clock
  input  wire logic         RESET,         // Asynchronous reset, high
  input  wire logic         LOCKOUT,       // Supply below turn-on level
  input  wire logic         CS_AT_FB,      // Sense reached feedback level
  input  wire logic         CS_AT_LIMIT,   // Sense reached OCP_THRESH
  input  wire logic         FB_OPEN,       // Feedback at open fault level
  input  wire logic         FLOAT_CS,      // Sense pin floating
  input  wire logic         FLOAT_FB,      // Feedback pin floating
  input  wire logic         FLOAT_DEM,     // Demag pin floating
  input  wire logic         DEMAG_VALLEY,  // Demag valley detected
  input  wire logic         PLATEAU_HIGH,  // Plateau above trip level
  input  wire logic         CCM_MODE,      // Fixed-frequency CCM selected
  output logic              GATE,          // Power switch gate drive
  output fbst_pkg::fbst_mv_t OCP_THRESH,   // Overcurrent threshold, mV
  output logic              SLOPE_COMP_EN, // Slope compensation on
  output logic              SS_ACTIVE,     // Soft start in progress
  output logic              FAULT_OVP,     // Over-voltage stop latched
  output logic              FAULT_OLP      // Overload stop latched
);
  import fbst_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [9:0]  pin_raw;
  logic [9:0]  sync1_q;
  logic [9:0]  sync2_q;
  logic        lock_s;
  logic        cs_fb_s;
  logic        cs_lim_s;
  logic        fb_open_s;
  logic        float_s;
  logic        valley_s;
  fbst_state_t state_q;
  fbst_state_t state_d;
  logic        gate_q;
  logic [10:0] on_cnt_q;
  logic [7:0]  supp_cnt_q;
  logic [31:0] per_q;
  logic [31:0] olp_cnt_q;
  logic        olp_q;
  logic [31:0] ss_cnt_q;
  logic        ss_act_q;
  fbst_mv_t    thr_q;
  fbst_mv_t    thr_time;
  fbst_mv_t    thr_soft;
  logic        inhibit;
  logic        blank_done;
  logic        ton_done;
  logic        on_end;
  logic        supp_done;
  logic        per_ok;
  logic        start_ok;
  logic        cycle_start;

  fbst_if bus (
    .clk (CLK),
    .rst (RESET)
  );

  // ----------------------------------------------------------------
  // Threshold interpolation between the low and high limits
  // ----------------------------------------------------------------
  function automatic fbst_mv_t fbst_lerp(input logic [31:0] elapsed, input logic [31:0] full);
    logic [31:0] span;
    span = 32'h0;
    if (elapsed >= full) begin
      return fbst_mv_t'(`FBST_OCP_HI_MV);
    end
    span = (elapsed * (`FBST_OCP_HI_MV - `FBST_OCP_LO_MV)) / full;
    return fbst_mv_t'(`FBST_OCP_LO_MV + span);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {CCM_MODE, PLATEAU_HIGH, DEMAG_VALLEY, FLOAT_DEM, FLOAT_FB,
                    FLOAT_CS, FB_OPEN, CS_AT_LIMIT, CS_AT_FB, LOCKOUT};

  // Two flops per pin; lockout reads as active in reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1_q <= `FBST_SYNC_RST;
      sync2_q <= `FBST_SYNC_RST;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // Synchronised pin names
  assign lock_s    = sync2_q[0];
  assign cs_fb_s   = sync2_q[1];
  assign cs_lim_s  = sync2_q[2];
  assign fb_open_s = sync2_q[3];
  assign float_s   = |sync2_q[6:4];
  assign valley_s  = sync2_q[7];

  // Helper interface wiring
  assign bus.clr           = lock_s;
  assign bus.cycle_start   = cycle_start;
  assign bus.flyback_start = (state_q == FBST_ON) && (state_d == FBST_SUPP);
  assign bus.plateau_high  = sync2_q[8];
  assign bus.ccm_mode      = sync2_q[9];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  fbst_ovp u_ovp (
    .bus (bus.ovp)
  );

  fbst_ccm u_ccm (
    .bus (bus.ccm)
  );

  // ----------------------------------------------------------------
  // Gate inhibit and cycle conditions
  // ----------------------------------------------------------------
  assign inhibit = lock_s | float_s | bus.ovp_fault | olp_q;

  // Comparators only count once blanking is over
  assign blank_done = on_cnt_q >= 11'(`FBST_BLANK_CYC);
  assign ton_done   = on_cnt_q >= 11'(`FBST_TON_MAX_CYC - 1);
  assign on_end     = ton_done || (blank_done && (cs_fb_s || cs_lim_s));
  assign supp_done  = supp_cnt_q == 8'(`FBST_SUPP_CYC - 1);
  assign per_ok     = per_q >= 32'(`FBST_PER_MIN_CYC);

  // Valley ends off-phase in QR; CCM uses its own period
  assign start_ok = per_ok && (bus.ccm_mode ? bus.ccm_tick
                                            : (valley_s || per_q >= OFF_MAX_CYC));
  assign cycle_start = (state_q != FBST_ON) && (state_d == FBST_ON);

  // ----------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------
  // Inhibit overrides every phase change
  always_comb begin
    state_d = state_q;
    if (inhibit) begin
      state_d = FBST_IDLE;
    end else begin
      unique case (state_q)
        FBST_IDLE: begin
          if (per_ok) begin
            state_d = FBST_ON;
          end
        end
        FBST_ON: begin
          if (on_end) begin
            state_d = FBST_SUPP;
          end
        end
        FBST_SUPP: begin
          if (supp_done) begin
            state_d = FBST_OFF;
          end
        end
        FBST_OFF: begin
          if (start_ok) begin
            state_d = FBST_ON;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= FBST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Gate follows the next state so it lines up with state_q
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= (state_d == FBST_ON) && !inhibit;
    end
  end

  // ----------------------------------------------------------------
  // Phase timers
  // ----------------------------------------------------------------
  // On-time counter, zero in the first gate-high cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      on_cnt_q <= 11'h000;
    end else if (state_q == FBST_ON && state_d == FBST_ON) begin
      on_cnt_q <= on_cnt_q + 11'h001;
    end else begin
      on_cnt_q <= 11'h000;
    end
  end

  // Ringing suppression counter
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      supp_cnt_q <= 8'h00;
    end else if (state_q == FBST_SUPP && !supp_done) begin
      supp_cnt_q <= supp_cnt_q + 8'h01;
    end else begin
      supp_cnt_q <= 8'h00;
    end
  end

  // Period since last cycle start, saturating
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      per_q <= 32'h0;
    end else if (cycle_start) begin
      per_q <= 32'h1;
    end else if (per_q != 32'hffffffff) begin
      per_q <= per_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Overload guard
  // ----------------------------------------------------------------
  // Persistence counter of the open feedback level
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      olp_cnt_q <= 32'h0;
    end else if (!fb_open_s || lock_s || olp_q) begin
      olp_cnt_q <= 32'h0;
    end else begin
      olp_cnt_q <= olp_cnt_q + 32'h1;
    end
  end

  // Overload stop, cleared only by supply lockout
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      olp_q <= 1'b0;
    end else if (lock_s) begin
      olp_q <= 1'b0;
    end else if (olp_cnt_q >= OLP_CYC) begin
      olp_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Soft start and threshold selection
  // ----------------------------------------------------------------
  // Ramp restarts after every lockout or fault stop
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ss_cnt_q <= 32'h0;
    end else if (lock_s || olp_q || bus.ovp_fault) begin
      ss_cnt_q <= 32'h0;
    end else if (ss_cnt_q < SS_CYC) begin
      ss_cnt_q <= ss_cnt_q + 32'h1;
    end
  end

  // Soft start flag
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ss_act_q <= 1'b1;
    end else begin
      ss_act_q <= ss_cnt_q < SS_CYC;
    end
  end

  // Time-based threshold clamps at the high limit
  assign thr_time = fbst_lerp(32'(on_cnt_q), 32'(`FBST_TON_MAX_CYC));
  assign thr_soft = fbst_lerp(ss_cnt_q, SS_CYC);

  // Lower of the on-time and soft-start thresholds
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      thr_q <= fbst_mv_t'(`FBST_OCP_LO_MV);
    end else begin
      thr_q <= (thr_soft < thr_time) ? thr_soft : thr_time;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign GATE          = gate_q;
  assign OCP_THRESH    = thr_q;
  assign SLOPE_COMP_EN = bus.slope_en;
  assign SS_ACTIVE     = ss_act_q;
  assign FAULT_OVP     = bus.ovp_fault;
  assign FAULT_OLP     = olp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_BLANK_HOLD: assert property (@(posedge CLK) disable iff (RESET)
    state_q == FBST_ON && !blank_done && !ton_done && !inhibit |=> state_q == FBST_ON)
    else $error("on-phase ended inside blanking window");
  AST_MIN_ON: assert property (@(posedge CLK) disable iff (RESET)
    $fell(GATE) && !$past(inhibit) |-> $past(on_cnt_q) >= 11'(`FBST_BLANK_CYC))
    else $error("gate pulse shorter than blanking window");
  AST_MAX_ON: assert property (@(posedge CLK) disable iff (RESET)
    state_q == FBST_ON |-> on_cnt_q < 11'(`FBST_TON_MAX_CYC))
    else $error("on-phase longer than maximum on-time");
  AST_MIN_PERIOD: assert property (@(posedge CLK) disable iff (RESET)
    cycle_start |-> per_q >= 32'(`FBST_PER_MIN_CYC))
    else $error("cycle started faster than frequency clamp");
  AST_FB_OFF: assert property (@(posedge CLK) disable iff (RESET)
    state_q == FBST_ON && blank_done && cs_fb_s && !inhibit |=> state_q == FBST_SUPP ##0 !GATE)
    else $error("feedback trip did not start suppression");
  AST_SUPP_OFF: assert property (@(posedge CLK) disable iff (RESET)
    state_q == FBST_SUPP |-> !GATE && !cycle_start)
    else $error("gate on during suppression");
  AST_SUPP_LEN: assert property (@(posedge CLK) disable iff (RESET)
    $fell(state_q == FBST_SUPP) && !$past(inhibit) |-> $past(supp_cnt_q) == 8'(`FBST_SUPP_CYC - 1))
    else $error("suppression length wrong");
  AST_THR_RANGE: assert property (@(posedge CLK) disable iff (RESET)
    OCP_THRESH >= 10'(`FBST_OCP_LO_MV) && OCP_THRESH <= 10'(`FBST_OCP_HI_MV))
    else $error("threshold outside its band");
  AST_THR_CLAMP: assert property (@(posedge CLK) disable iff (RESET)
    on_cnt_q >= 11'(`FBST_TON_MAX_CYC) |-> thr_time == 10'(`FBST_OCP_HI_MV))
    else $error("threshold not clamped at high limit");
  AST_OLP_STOP: assert property (@(posedge CLK) disable iff (RESET)
    olp_q |=> !GATE)
    else $error("gate pulsed after overload stop");
  AST_FLOAT: assert property (@(posedge CLK) disable iff (RESET)
    float_s |=> !GATE)
    else $error("gate pulsed with floating input");
  AST_LOCKOUT: assert property (@(posedge CLK) disable iff (RESET)
    lock_s |=> !GATE && !olp_q && !FAULT_OVP)
    else $error("lockout did not hold gate low and clear faults");
  AST_INHIBIT: assert property (@(posedge CLK) disable iff (RESET)
    inhibit |=> state_q == FBST_IDLE ##0 !GATE)
    else $error("inhibit did not override turn-on");
endmodule

// >>> tb/fbst_switch_model.sv
// Power switch and auxiliary winding model seen from the gate
`timescale 1ns/1ps
module fbst_switch_model (
  input  wire logic        CLK,         // Block clock
  input  wire logic        GATE,        // Gate drive
  input  wire logic [11:0] TRIP,        // On cycles to sense trip, 0 never
  input  wire logic [11:0] VWAIT,       // Off cycles to valley
  output logic             CS_AT_FB,    // Sense reached feedback
  output logic             DEMAG_VALLEY // Valley seen
);
  logic        gate_q = 1'b0;   // Matches the idle gate level
  logic [11:0] cnt_q  = 12'h000; // Keeps the valley output known before the first pulse
  // Count cycles of the present gate phase
  always_ff @(posedge CLK) begin
    gate_q <= GATE;
    cnt_q <= (GATE != gate_q) ? 12'h000 : cnt_q + 12'h001;
  end
  // Current ramps while on, ringing decays while off
  assign CS_AT_FB = GATE && TRIP != 12'h000 && cnt_q >= TRIP;
  assign DEMAG_VALLEY = !GATE && cnt_q >= VWAIT;
endmodule

// >>> tb/test_flyback_switch_timing_protection.sv
// Self-checking bench of the flyback timing and protection block
`timescale 1ns/1ps
module test_flyback_switch_timing_protection;
  import fbst_pkg::*;
  logic clk = 0, rst = 1, lock = 1, fbo = 0, lim = 0, plat = 0, ccm = 0, gate_p = 0;
  logic [2:0] flt = 3'h0;
  logic [11:0] trip = 12'h001, vwait = 12'h190;
  logic gate, cs, vly, slope, ss, fovp, folp;
  fbst_mv_t overcurrent_limit;
  int fail_count = 0, num_checks = 0, run = 0, on_len = 0, off_len = 0, n_on = 0;
  // Clock
  initial forever #5 clk = ~clk;
  fbst_top #(.OLP_CYC(2000), .SS_CYC(500), .OFF_MAX_CYC(3000)) fbst_top_i (
    .CLK(clk), .RESET(rst), .LOCKOUT(lock), .CS_AT_FB(cs), .CS_AT_LIMIT(lim),
    .FB_OPEN(fbo), .FLOAT_CS(flt[0]), .FLOAT_FB(flt[1]), .FLOAT_DEM(flt[2]),
    .DEMAG_VALLEY(vly), .PLATEAU_HIGH(plat), .CCM_MODE(ccm), .GATE(gate), .OCP_THRESH(overcurrent_limit),
    .SLOPE_COMP_EN(slope), .SS_ACTIVE(ss), .FAULT_OVP(fovp), .FAULT_OLP(folp));
  fbst_switch_model fbst_switch_model_i (.CLK(clk), .GATE(gate), .TRIP(trip), .VWAIT(vwait),
    .CS_AT_FB(cs), .DEMAG_VALLEY(vly));
  // Measure on and off lengths of the gate
  always @(posedge clk) begin
    if (gate === gate_p) run++;
    else begin
      if (gate_p) on_len = run;
      else begin
        off_len = run;
        n_on++;
      end
      run = 1;
    end
    gate_p = gate;
  end
  task automatic check(input logic [31:0] got, exp, input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic starts(input int n);
    int s;
    s = n_on;
    for (int i = 0; i < 9000 * n && n_on < s + n; i++) @(negedge clk);
    if (n_on < s + n) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, n_on - s, n);
    end
  endtask
  task automatic idle(input logic [2:0] f, input logic l);
    int s;
    flt = f;
    lock = l;
    repeat (5) @(negedge clk);
    s = n_on;
    repeat (1200) @(negedge clk);
    check(n_on, s, n_on === s && gate === 1'b0);
    flt = 3'h0;
    lock = 0;
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    check(overcurrent_limit, 10'h1c2, overcurrent_limit === 10'h1c2);
    lock = 0;
    starts(3);
    check(on_len, 31, on_len >= 31 && on_len <= 35);
    check(on_len + off_len, 1053, on_len + off_len >= 1053);
    trip = 12'h000;
    lim = 1;
    starts(2);
    check(on_len, 31, on_len >= 31 && on_len <= 35);
    lim = 0;
    trip = 12'h384;
    vwait = 12'h002;
    starts(2);
    check(off_len, 250, on_len >= 900 && on_len <= 906 && off_len >= 250 && off_len <= 256);
    trip = 12'h000;
    starts(2);
    check(on_len, 1250, on_len >= 1245 && on_len <= 1251);
    repeat (600) @(negedge clk);
    check(overcurrent_limit, 10'h26a, overcurrent_limit >= 10'h258 && overcurrent_limit <= 10'h280);
    trip = 12'h064;
    ccm = 1;
    starts(3);
    check(on_len + off_len, 1923, slope === 1'b1 && on_len + off_len >= 1827 && on_len + off_len <= 2019);
    ccm = 0;
    repeat (5) @(negedge clk);
    check(slope, 0, slope === 1'b0);
    idle(3'h4, 0);
    idle(3'h1, 0);
    idle(3'h0, 1);
    plat = 1;
    starts(3);
    plat = 0;
    starts(2);
    plat = 1;
    starts(3);
    check(fovp, 0, fovp === 1'b0);
    repeat (4000) @(negedge clk);
    plat = 0;
    check(fovp, 1, fovp === 1'b1 && gate === 1'b0);
    repeat (3000) @(negedge clk);
    check(fovp, 1, fovp === 1'b1 && gate === 1'b0);
    idle(3'h0, 1);
    repeat (5) @(negedge clk);
    check(fovp, 0, fovp === 1'b0);
    fbo = 1;
    repeat (2100) @(negedge clk);
    check(folp, 1, folp === 1'b1 && gate === 1'b0);
    fbo = 0;
    idle(3'h0, 1);
    repeat (5) @(negedge clk);
    check(folp, 0, folp === 1'b0 && ss === 1'b1);
    repeat (600) @(negedge clk);
    check(ss, 0, ss === 1'b0);
    test_done();
  end
  // Watchdog
  initial begin
    #800000;
    fail_count++;
    test_done();
  end
endmodule
